/* hdl/pio_pkg.sv */
// Package of constants for the parallel port and comparator block.
package pio_pkg;
	// ----------------------------------------------------------------
	// Register offsets (word addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] PIO_OFS_DATA = 4'h0;
	localparam logic [3:0] PIO_OFS_DIR = 4'h1;
	localparam logic [3:0] PIO_OFS_PORT_CONFIG_REGISTER = 4'h2;
	localparam logic [3:0] PIO_OFS_P3M = 4'h3;
	localparam logic [3:0] PIO_OFS_IRQ = 4'h4;
	localparam logic [3:0] PIO_OFS_STAT = 4'h5;
	localparam logic [3:0] PIO_OFS_MASK = 4'h6;
	localparam logic [3:0] PIO_OFS_CTSEL = 4'h7;
	localparam logic [3:0] PIO_OFS_P3IN = 4'h8;
	// ----------------------------------------------------------------
	// Field positions and values
	// ----------------------------------------------------------------
	localparam int PIO_PORT_CONFIG_REGISTER_OD_BIT = 1;
	localparam int PIO_P3M_ANA_BIT = 1;
	localparam int PIO_IRQ_EDGE_LO = 6;
	localparam int PIO_IRQ_EDGE_HI = 7;
	localparam int PIO_STAT_A_BIT = 0;
	localparam int PIO_STAT_B_BIT = 1;
	localparam logic [7:0] PIO_ALL_ONES = 8'hFF;
	localparam logic [7:0] PIO_ZERO8 = 8'h00;
	localparam logic [31:0] PIO_ZERO32 = 32'h00000000;
	localparam logic [1:0] PIO_EDGE_FALL = 2'h0;
	localparam logic [1:0] PIO_EDGE_RISE = 2'h1;
	localparam logic [1:0] PIO_EDGE_BOTH = 2'h2;
	localparam logic [1:0] PIO_ZERO2 = 2'h0;
	localparam logic [31:0] PIO_UNMAPPED = 32'hDEADBEEF;
endpackage : pio_pkg

/* hdl/pio_port.sv */
// Parallel port, comparator edge interrupts and timer input select.
// Summary of operation
// - After reset or stop-mode recovery every port bit is an input.
// - Bit D1 of the port config register picks open-drain over push-pull.
// - On small packages port writes are ignored and reads return all ones.
// - Two comparators each compare an analog input with its reference.
// - Comparators act only with port 3 mode bit 1 set, else pins are digital.
// - Each comparator pin raises an interrupt on rise, fall or both edges.
// - Timer edge input comes from comparator A pin or the alternate pin.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module pio_port
	import pio_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic stop_mode_recovery_in,
	input wire logic small_pkg_in,
	input wire logic [7:0] gp_port_pins_in,
	output logic [7:0] gp_port_pins_out,
	output logic [7:0] gp_port_pins_oe_n_out,
	input wire logic comparator_a_input_in,
	input wire logic comparator_b_input_in,
	input wire logic comp_a_gt_ref_in,
	input wire logic comp_b_gt_ref_in,
	input wire logic alt_edge_input_in,
	output logic timer_edge_out,
	output logic irq_out,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// The comparator outputs are asynchronous analog results, so they are
	// treated exactly like pins.
	logic [12:0] s1_r;
	logic [12:0] s2_r;
	logic [12:0] s3_r;
	logic [12:0] s1_nxt;
	logic [12:0] s2_nxt;
	logic [12:0] s3_nxt;
	logic [7:0] gp_sync;
	logic pa_s;
	logic pb_s;
	logic ca_s;
	logic cb_s;
	logic alt_s;
	// The third stage only keeps the previous synced level for edges.
	logic pa_prev;
	logic pb_prev;
	logic ca_prev;
	logic cb_prev;
	logic alt_prev;

	always_comb begin
		s1_nxt = {alt_edge_input_in, comp_b_gt_ref_in, comp_a_gt_ref_in,
			comparator_b_input_in, comparator_a_input_in, gp_port_pins_in};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s1_r <= 13'h0000;
			s2_r <= 13'h0000;
			s3_r <= 13'h0000;
		end else if (clk_en_in) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	assign gp_sync = s2_r[7:0];
	assign pa_s = s2_r[8];
	assign pb_s = s2_r[9];
	assign ca_s = s2_r[10];
	assign cb_s = s2_r[11];
	assign alt_s = s2_r[12];
	assign pa_prev = s3_r[8];
	assign pb_prev = s3_r[9];
	assign ca_prev = s3_r[10];
	assign cb_prev = s3_r[11];
	assign alt_prev = s3_r[12];

	// ----------------------------------------------------------------
	// Edge detection function
	// ----------------------------------------------------------------
	function automatic logic pio_edge(input logic cur, input logic prv,
		input logic [1:0] sel);
		logic hit;
		hit = 1'b0;
		case (sel)
			PIO_EDGE_RISE: hit = cur & ~prv;
			PIO_EDGE_FALL: hit = ~cur & prv;
			default: hit = cur ^ prv;
		endcase
		return hit;
	endfunction : pio_edge

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] data_r;
	logic [7:0] dir_r;
	logic [7:0] port_config_register_r;
	logic [7:0] p3m_r;
	logic [7:0] irq_r;
	logic [7:0] mask_r;
	logic [1:0] stat_r;
	logic ctsel_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [7:0] data_nxt;
	logic [7:0] dir_nxt;
	logic [7:0] port_config_register_nxt;
	logic [7:0] p3m_nxt;
	logic [7:0] irq_nxt;
	logic [7:0] mask_nxt;
	logic [1:0] stat_nxt;
	logic [1:0] ev;
	logic ctsel_nxt;
	logic wait_nxt;
	logic [31:0] rdata_nxt;
	logic ana_en;
	logic a_lvl;
	logic a_prv;
	logic b_lvl;
	logic b_prv;
	logic wr_go;
	logic rd_go;

	assign ana_en = p3m_r[PIO_P3M_ANA_BIT];
	assign a_lvl = ana_en ? ca_s : pa_s;
	assign a_prv = ana_en ? ca_prev : pa_prev;
	assign b_lvl = ana_en ? cb_s : pb_s;
	assign b_prv = ana_en ? cb_prev : pb_prev;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// A request is answered one cycle after it is raised.
	assign wr_go = avs_write & ~wait_r;
	// Read data are latched in the first cycle, so that they already
	// stand at the edge where the master sees waitrequest low.
	assign rd_go = avs_read & wait_r;

	always_comb begin
		data_nxt = data_r;
		dir_nxt = dir_r;
		port_config_register_nxt = port_config_register_r;
		p3m_nxt = p3m_r;
		irq_nxt = irq_r;
		mask_nxt = mask_r;
		ctsel_nxt = ctsel_r;
		stat_nxt = stat_r;
		rdata_nxt = rdata_r;
		wait_nxt = 1'b1;
		if ((avs_read | avs_write) & wait_r) begin
			wait_nxt = 1'b0;
		end
		ev[PIO_STAT_A_BIT] = pio_edge(a_lvl, a_prv,
			irq_r[PIO_IRQ_EDGE_HI:PIO_IRQ_EDGE_LO]);
		ev[PIO_STAT_B_BIT] = pio_edge(b_lvl, b_prv,
			irq_r[PIO_IRQ_EDGE_HI:PIO_IRQ_EDGE_LO]);
		if (wr_go) begin
			case (avs_address)
				PIO_OFS_DATA: if (!small_pkg_in) begin
					data_nxt = avs_writedata[7:0];
				end
				PIO_OFS_DIR: if (!small_pkg_in) begin
					dir_nxt = avs_writedata[7:0];
				end
				PIO_OFS_PORT_CONFIG_REGISTER: port_config_register_nxt = avs_writedata[7:0];
				PIO_OFS_P3M: p3m_nxt = avs_writedata[7:0];
				PIO_OFS_IRQ: irq_nxt = avs_writedata[7:0];
				PIO_OFS_STAT: stat_nxt = stat_r & ~avs_writedata[1:0];
				PIO_OFS_MASK: mask_nxt = avs_writedata[7:0];
				PIO_OFS_CTSEL: ctsel_nxt = avs_writedata[0];
				default: ;
			endcase
		end
		// Set wins over a simultaneous write-one clear.
		stat_nxt = stat_nxt | ev;
		if (stop_mode_recovery_in) begin
			dir_nxt = PIO_ZERO8;
		end
		if (rd_go) begin
			case (avs_address)
				PIO_OFS_DATA: rdata_nxt = {24'h000000,
					small_pkg_in ? PIO_ALL_ONES : gp_sync};
				PIO_OFS_DIR: rdata_nxt = {24'h000000,
					small_pkg_in ? PIO_ALL_ONES : dir_r};
				PIO_OFS_PORT_CONFIG_REGISTER: rdata_nxt = {24'h000000, port_config_register_r};
				PIO_OFS_P3M: rdata_nxt = {24'h000000, p3m_r};
				PIO_OFS_IRQ: rdata_nxt = {24'h000000, irq_r};
				PIO_OFS_STAT: rdata_nxt = {30'h00000000, stat_r};
				PIO_OFS_MASK: rdata_nxt = {24'h000000, mask_r};
				PIO_OFS_CTSEL: rdata_nxt = {31'h00000000, ctsel_r};
				PIO_OFS_P3IN: rdata_nxt = {27'h0000000, alt_s, b_lvl,
					a_lvl, 2'h0};
				default: rdata_nxt = PIO_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			data_r <= PIO_ZERO8;
			dir_r <= PIO_ZERO8;
			port_config_register_r <= PIO_ZERO8;
			p3m_r <= PIO_ZERO8;
			irq_r <= PIO_ZERO8;
			mask_r <= PIO_ZERO8;
			stat_r <= PIO_ZERO2;
			ctsel_r <= 1'b0;
			wait_r <= 1'b1;
			rdata_r <= PIO_ZERO32;
		end else if (clk_en_in) begin
			data_r <= data_nxt;
			dir_r <= dir_nxt;
			port_config_register_r <= port_config_register_nxt;
			p3m_r <= p3m_nxt;
			irq_r <= irq_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			ctsel_r <= ctsel_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic [7:0] pout_r;
	logic [7:0] poe_n_r;
	logic [7:0] pout_nxt;
	logic [7:0] poe_n_nxt;
	logic tedge_r;
	logic irq_r2;
	logic tedge_nxt;
	logic irq_nxt2;

	always_comb begin
		pout_nxt = data_r;
		poe_n_nxt = ~dir_r;
		if (port_config_register_r[PIO_PORT_CONFIG_REGISTER_OD_BIT]) begin
			pout_nxt = PIO_ZERO8;
			poe_n_nxt = ~(dir_r & ~data_r);
		end
		if (small_pkg_in) begin
			poe_n_nxt = PIO_ALL_ONES;
		end
		tedge_nxt = ctsel_r ? alt_s : a_lvl;
		irq_nxt2 = |(stat_r & mask_r[1:0]);
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pout_r <= PIO_ZERO8;
			poe_n_r <= PIO_ALL_ONES;
			tedge_r <= 1'b0;
			irq_r2 <= 1'b0;
		end else if (clk_en_in) begin
			pout_r <= pout_nxt;
			poe_n_r <= poe_n_nxt;
			tedge_r <= tedge_nxt;
			irq_r2 <= irq_nxt2;
		end
	end

	assign gp_port_pins_out = pout_r;
	assign gp_port_pins_oe_n_out = poe_n_r;
	assign timer_edge_out = tedge_r;
	assign irq_out = irq_r2;
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
endmodule : pio_port

/* bench/pio_pins_model.sv */
// Far-side model: port wires with pull-ups and the two comparators.
`timescale 1ns/1ps
module pio_pins_model (
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_n_in,
	input wire logic [7:0] ana_a_in,
	input wire logic [7:0] ana_b_in,
	input wire logic [7:0] ref_in,
	output logic [7:0] pins_out,
	output logic a_gt_out,
	output logic b_gt_out
);
	// wire resolution
	// A released line shows its pull-up, never the last driven value.
	assign pins_out = (~oe_n_in & drv_in) | oe_n_in;
	assign a_gt_out = ana_a_in > ref_in;
	assign b_gt_out = ana_b_in > ref_in;
endmodule : pio_pins_model

/* bench/pio_port_props.sv */
// Checker of port timing for the parallel port block.
`timescale 1ns/1ps
module pio_port_props
	import pio_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic stop_mode_recovery_in,
	input wire logic small_pkg_in,
	input wire logic [7:0] gp_port_pins_oe_n_out,
	input wire logic irq_out,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest && clk_en_in;
	endsequence
	sequence s_small_rd;
		s_req ##0 avs_read && small_pkg_in && avs_address == PIO_OFS_DATA;
	endsequence
	a_reset_dir_in: assert property ($fell(rst_in) |->
		gp_port_pins_oe_n_out == PIO_ALL_ONES && !irq_out)
		else $error("port not input after reset");
	a_smr_dir_in: assert property (stop_mode_recovery_in && clk_en_in |->
		##2 gp_port_pins_oe_n_out == PIO_ALL_ONES)
		else $error("recovery kept drive");
	a_small_undriven: assert property (small_pkg_in && clk_en_in |=>
		gp_port_pins_oe_n_out == PIO_ALL_ONES) else $error("reserved port driven");
	a_small_reads_ones: assert property (s_small_rd |=>
		avs_readdata == {24'h000000, PIO_ALL_ONES}) else $error("reserved read");
	a_answer_one: assert property (s_req |=> !avs_waitrequest)
		else $error("answer late");
	a_answer_once: assert property (!avs_waitrequest && clk_en_in |=>
		avs_waitrequest) else $error("answer held");
	a_readdata_hold: assert property ($changed(avs_readdata) |->
		$past(avs_read)) else $error("read data moved");
	a_state_frozen: assert property (!clk_en_in |=>
		$stable(gp_port_pins_oe_n_out) && $stable(irq_out)) else $error("froze");
endmodule : pio_port_props
bind pio_port pio_port_props u_props (.*);

/* bench/pio_port_tb.sv */
// Self-checking testbench for the parallel port block.
`timescale 1ns/1ps
module pio_port_tb
	import pio_pkg::*;
;
	logic sys_clk_in = 1'h0, rst_in = 1'h1, clk_en_in = 1'h1;
	logic stop_mode_recovery_in = 1'h0, small_pkg_in = 1'h0;
	logic comparator_a_input_in = 1'h0, comparator_b_input_in = 1'h0;
	logic alt_edge_input_in = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = PIO_ZERO32, avs_readdata, got;
	logic [7:0] va = 8'h00, vb = 8'h00;
	logic [7:0] gp_port_pins_in, gp_port_pins_out, gp_port_pins_oe_n_out;
	logic comp_a_gt_ref_in, comp_b_gt_ref_in, timer_edge_out;
	logic irq_out, avs_waitrequest;
	int bad_count = 0;
	int n_checks = 0;
	always #2.5 sys_clk_in = ~sys_clk_in;
	pio_port dut (.*);
	pio_pins_model pm (.drv_in(gp_port_pins_out),
		.oe_n_in(gp_port_pins_oe_n_out), .ana_a_in(va), .ana_b_in(vb),
		.ref_in(8'h80), .pins_out(gp_port_pins_in),
		.a_gt_out(comp_a_gt_ref_in), .b_gt_out(comp_b_gt_ref_in));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	// Requests are held until the edge that samples waitrequest low.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge sys_clk_in); while (avs_waitrequest !== 1'h0);
		got = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : bus
	task rc(input string n, input logic [3:0] a, input logic [31:0] e);
		bus(1'h0, a, PIO_ZERO32);
		chk(n, e, got);
	endtask : rc
	task waitn(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : waitn
	task t_dir;
		rc("dir", PIO_OFS_DIR, 32'h0);
		chk("oe_n", 32'hFF, gp_port_pins_oe_n_out);
		bus(1'h1, PIO_OFS_DIR, 32'hFF);
		bus(1'h1, PIO_OFS_DATA, 32'hA5);
		waitn(2);
		chk("push", 32'hA5, gp_port_pins_out);
		chk("oe_n", 32'h0, gp_port_pins_oe_n_out);
		rc("pins", PIO_OFS_DATA, 32'hA5);
		bus(1'h1, PIO_OFS_PORT_CONFIG_REGISTER, 32'h2);
		waitn(2);
		chk("od", 32'h0, gp_port_pins_out);
		chk("od oe_n", 32'hA5, gp_port_pins_oe_n_out);
		stop_mode_recovery_in <= 1'h1;
		waitn(1);
		stop_mode_recovery_in <= 1'h0;
		waitn(2);
		chk("smr", 32'hFF, gp_port_pins_oe_n_out);
		bus(1'h1, PIO_OFS_PORT_CONFIG_REGISTER, 32'h0);
	endtask : t_dir
	task t_small;
		small_pkg_in <= 1'h1;
		bus(1'h1, PIO_OFS_DIR, 32'hFF);
		waitn(2);
		chk("small oe_n", 32'hFF, gp_port_pins_oe_n_out);
		rc("small rd", PIO_OFS_DATA, 32'hFF);
		small_pkg_in <= 1'h0;
		rc("small dir", PIO_OFS_DIR, 32'h0);
		rc("unmapped", 4'hF, PIO_UNMAPPED);
	endtask : t_small
	task t_irq;
		bus(1'h1, PIO_OFS_MASK, 32'h3);
		for (int m = 0; m < 3; m++) begin
			bus(1'h1, PIO_OFS_IRQ, 32'(m) << 6);
			comparator_a_input_in <= 1'h1;
			comparator_b_input_in <= 1'h1;
			waitn(8);
			rc("rise", PIO_OFS_STAT, (m != 0) ? 32'h3 : 32'h0);
			chk("irq", 32'(m != 0), irq_out);
			bus(1'h1, PIO_OFS_STAT, 32'h3);
			comparator_a_input_in <= 1'h0;
			comparator_b_input_in <= 1'h0;
			waitn(8);
			rc("fall", PIO_OFS_STAT, (m != 1) ? 32'h3 : 32'h0);
			bus(1'h1, PIO_OFS_STAT, 32'h3);
		end
		bus(1'h1, PIO_OFS_P3M, 32'h2);
		comparator_a_input_in <= 1'h1;
		waitn(8);
		rc("analog pin", PIO_OFS_STAT, 32'h0);
		va <= 8'h90;
		waitn(8);
		rc("analog", PIO_OFS_STAT, 32'h1);
		bus(1'h1, PIO_OFS_MASK, 32'h0);
		waitn(2);
		chk("masked", 32'h0, irq_out);
		bus(1'h1, PIO_OFS_STAT, 32'h3);
		rc("cleared", PIO_OFS_STAT, 32'h0);
	endtask : t_irq
	task t_tmr;
		bus(1'h1, PIO_OFS_CTSEL, 32'h1);
		alt_edge_input_in <= 1'h1;
		waitn(6);
		chk("alt", 32'h1, timer_edge_out);
		va <= 8'h00;
		bus(1'h1, PIO_OFS_CTSEL, 32'h0);
		waitn(6);
		chk("comp a", 32'h0, timer_edge_out);
		bus(1'h1, PIO_OFS_CTSEL, 32'h1);
		waitn(6);
		clk_en_in <= 1'h0;
		alt_edge_input_in <= 1'h0;
		waitn(6);
		chk("frozen", 32'h1, timer_edge_out);
		clk_en_in <= 1'h1;
		waitn(6);
		chk("thawed", 32'h0, timer_edge_out);
	endtask : t_tmr
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		waitn(3);
		rst_in <= 1'h0;
		t_dir();
		t_small();
		t_irq();
		t_tmr();
		give_verdict();
	end
	// The run needs about 210 cycles; 3000, over ten times that, is a hang.
	initial begin
		waitn(3000);
		bad_count++;
		give_verdict();
	end
endmodule : pio_port_tb
